/* File: asp_pkg.sv */
package asp_pkg;
  // Serial word and field layout
  localparam int ASP_WORD_BITS     = 16;
  localparam int ASP_CNT_BITS      = 5;
  localparam int ASP_RESULT_BITS   = 14;
  localparam int ASP_CTRL_CONV_BIT = 15;
  // Conversion timing
  localparam int ASP_CONV_CYCLES   = 21;
  localparam int ASP_CONV_CNT_BITS = 6;
  localparam logic [15:0] ASP_RESULT_RESET = 16'h0000;
  localparam logic [15:0] ASP_CTRL_RESET   = 16'h0000;

  typedef enum logic [1:0] {ASP_IDLE, ASP_CONV, ASP_DONE} asp_conv_state_t;
endpackage

/* File: asp_link.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Link-side shifter, clocked by the serial clock
// ----------------------------------------------------------------------
module asp_link
  import asp_pkg::*;
(
  input  wire logic        serial_clk,
  input  wire logic        reset,
  input  wire logic        frame_sel_n,
  input  wire logic        data_in,
  input  wire logic [15:0] tx_word,
  output logic             data_out,
  output logic             data_out_en,
  output logic [15:0]      rx_word,
  output logic             word_toggle
);
  logic [ASP_CNT_BITS-1:0] cnt_q, cnt_d;
  logic [15:0]             rx_sh_q, rx_sh_d;
  logic [15:0]             tx_sh_q, tx_sh_d;
  logic [15:0]             rx_word_q, rx_word_d;
  logic                    tog_q, tog_d;

  // Frame select high clears the bit count; works with it tied low too
  always_comb
  begin
    cnt_d     = cnt_q;
    rx_sh_d   = rx_sh_q;
    rx_word_d = rx_word_q;
    tog_d     = tog_q;
    if (!frame_sel_n)
    begin
      rx_sh_d = {rx_sh_q[14:0], data_in};
      if (cnt_q == 5'(ASP_WORD_BITS - 1))
      begin
        cnt_d     = '0;
        rx_word_d = {rx_sh_q[14:0], data_in};
        tog_d     = ~tog_q;
      end
      else
        cnt_d = cnt_q + 5'h01;
    end
  end

  always_ff @(posedge serial_clk or posedge reset or posedge frame_sel_n)
  begin
    if (reset)
    begin
      cnt_q     <= '0;
      rx_sh_q   <= '0;
      rx_word_q <= '0;
      tog_q     <= 1'b0;
    end
    else if (frame_sel_n)
      cnt_q     <= '0;
    else
    begin
      cnt_q     <= cnt_d;
      rx_sh_q   <= rx_sh_d;
      rx_word_q <= rx_word_d;
      tog_q     <= tog_d;
    end
  end

  // Output shifts on falling edge; word loaded at frame start
  always_comb
  begin
    if (cnt_q == '0)
      tx_sh_d = {tx_word[14:0], 1'b0};
    else
      tx_sh_d = {tx_sh_q[14:0], 1'b0};
  end

  always_ff @(negedge serial_clk or posedge reset)
  begin
    if (reset)
    begin
      tx_sh_q  <= '0;
      data_out <= 1'b0;
    end
    else if (!frame_sel_n)
    begin
      tx_sh_q  <= tx_sh_d;
      data_out <= (cnt_q == '0) ? tx_word[15] : tx_sh_q[15];
    end
  end

  assign data_out_en = ~frame_sel_n;
  assign rx_word     = rx_word_q;
  assign word_toggle = tog_q;
endmodule // asp_link

/* File: asp_port.sv */
`timescale 1ns/10ps
// Contract
// - Frame select tied low still works
// - Busy output marks conversion end
// - Transfers allowed during conversion
// - Control in, previous result out together
// - First falling edge drives leading zero
// - Input sampled on rising clock edge
// - Frame select high resets interface
module asp_port
  import asp_pkg::*;
#(
  parameter int CONV_CYCLES = ASP_CONV_CYCLES
)
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        serial_clk,
  input  wire logic        frame_sel_n,
  input  wire logic        data_in,
  input  wire logic        convert_start_n,
  input  wire logic [13:0] conv_result,
  output logic             data_out,
  output logic             data_out_en,
  output logic             busy,
  output logic [15:0]      ctrl_word,
  output logic             ctrl_strobe
);
  // ----------------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------------
  logic [15:0] rx_word;
  logic        word_toggle;
  logic [15:0] result_q, result_d;

  // Result register only changes at conversion end; transfers while busy
  // therefore see the previous result, stable across the crossing
  asp_link u_link (
    .serial_clk  (serial_clk),
    .reset       (reset),
    .frame_sel_n (frame_sel_n),
    .data_in     (data_in),
    .tx_word     (result_q),
    .data_out    (data_out),
    .data_out_en (data_out_en),
    .rx_word     (rx_word),
    .word_toggle (word_toggle)
  );

  // ----------------------------------------------------------------------
  // Crossing into system clock
  // ----------------------------------------------------------------------
  logic [2:0] tog_sync_q, tog_sync_d;
  logic [1:0] cst_sync_q, cst_sync_d;
  logic       cst_prev_q, cst_prev_d;
  logic       word_evt;
  logic       cst_fall;

  always_comb
  begin
    tog_sync_d = {tog_sync_q[1:0], word_toggle};
    cst_sync_d = {cst_sync_q[0], convert_start_n};
    cst_prev_d = cst_sync_q[1];
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      tog_sync_q <= '0;
      cst_sync_q <= 2'h3;
      cst_prev_q <= 1'b1;
    end
    else
    begin
      tog_sync_q <= tog_sync_d;
      cst_sync_q <= cst_sync_d;
      cst_prev_q <= cst_prev_d;
    end
  end

  // Word stays stable for many serial clocks, so toggle-then-sample is safe
  assign word_evt = tog_sync_q[2] ^ tog_sync_q[1];
  assign cst_fall = cst_prev_q & ~cst_sync_q[1];

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  asp_conv_state_t             state_q, state_d;
  logic [ASP_CONV_CNT_BITS-1:0] cnt_q, cnt_d;
  logic                        busy_d;
  logic [15:0]                 ctrl_d;
  logic                        strobe_d;
  logic                        sw_start;

  assign sw_start = word_evt & rx_word[ASP_CTRL_CONV_BIT];

  always_comb
  begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    result_d = result_q;
    ctrl_d   = ctrl_word;
    strobe_d = 1'b0;
    if (word_evt)
    begin
      ctrl_d   = rx_word;
      strobe_d = 1'b1;
    end
    unique case (state_q)
      ASP_IDLE, ASP_DONE:
      begin
        state_d = ASP_IDLE;
        if (sw_start || cst_fall)
        begin
          state_d = ASP_CONV;
          cnt_d   = '0;
        end
      end
      ASP_CONV:
      begin
        if (cnt_q == ASP_CONV_CNT_BITS'(CONV_CYCLES - 1))
        begin
          state_d  = ASP_DONE;
          result_d = {2'b00, conv_result};
        end
        else
          cnt_d = cnt_q + 6'h01;
      end
    endcase
    busy_d = (state_d == ASP_CONV);
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_q     <= ASP_IDLE;
      cnt_q       <= '0;
      result_q    <= ASP_RESULT_RESET;
      ctrl_word   <= ASP_CTRL_RESET;
      ctrl_strobe <= 1'b0;
      busy        <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      result_q    <= result_d;
      ctrl_word   <= ctrl_d;
      ctrl_strobe <= strobe_d;
      busy        <= busy_d;
    end
  end
endmodule // asp_port

/* File: asp_asserts.sv */
`timescale 1ns/10ps
module asp_asserts
  import asp_pkg::*;
#(
  parameter int CONV_CYCLES = ASP_CONV_CYCLES
)
(
  input logic        sys_clk,
  input logic        reset,
  input logic        serial_clk,
  input logic        frame_sel_n,
  input logic        data_out,
  input logic        data_out_en,
  input logic        busy,
  input logic [15:0] ctrl_word,
  input logic        ctrl_strobe
);
  logic [6:0] run_q;
  logic [3:0] bit_q;
  always_ff @(posedge sys_clk or posedge reset)
    if (reset) run_q <= 7'h00;
    else run_q <= busy ? run_q + 7'h01 : 7'h00;
  // Raised frame clears the count at once
  always_ff @(posedge serial_clk or posedge reset or posedge frame_sel_n)
    if (reset || frame_sel_n) bit_q <= 4'h0;
    else bit_q <= bit_q + 4'h1;
  chk_oe_frame:
    assert property (@(posedge sys_clk) disable iff (reset)
      data_out_en == !frame_sel_n) else $error("enable");
  chk_busy_start:
    assert property (@(posedge sys_clk) disable iff (reset)
      ctrl_strobe && ctrl_word[ASP_CTRL_CONV_BIT] && !$past(busy) |-> busy)
      else $error("start");
  chk_busy_len:
    assert property (@(posedge sys_clk) disable iff (reset)
      $fell(busy) |-> run_q == CONV_CYCLES) else $error("length");
  chk_busy_hold:
    assert property (@(posedge sys_clk) disable iff (reset)
      busy && run_q < CONV_CYCLES - 1 |=> busy) else $error("hold");
  chk_strobe_gap:
    assert property (@(posedge sys_clk) disable iff (reset)
      ctrl_strobe |=> !ctrl_strobe [*8]) else $error("strobe");
  chk_word_hold:
    assert property (@(posedge sys_clk) disable iff (reset)
      $changed(ctrl_word) |-> ctrl_strobe || $past(ctrl_strobe)) else $error("word");
  chk_lead_zero:
    assert property (@(posedge serial_clk) disable iff (reset)
      !frame_sel_n && bit_q < 4'h2 |-> !data_out) else $error("lead");
  cover property (@(posedge sys_clk) ctrl_strobe && busy);
  cover property (@(posedge sys_clk) $fell(busy));
  cover property (@(posedge serial_clk) bit_q == 4'hF);
endmodule // asp_asserts

bind asp_port asp_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.*);

/* File: asp_host.sv */
`timescale 1ns/10ps
module asp_host
(
  output logic serial_clk,
  output logic frame_sel_n,
  output logic data_in,
  input  logic data_out
);
  initial
  begin
    serial_clk = 1'b1;
    frame_sel_n = 1'b1;
    data_in = 1'b0;
  end
  // Clock stands high between frames, so never a conversion clock
  // Half period 7.5 ns is faster than a real host would run
  task automatic xfer(input logic [15:0] w, input bit tie, sp, input int nb,
                      output logic [15:0] r);
    r = 16'h0000;
    frame_sel_n = 1'b0;
    #3.3;
    for (int i = 15; i > 15 - nb; i--)
    begin
      serial_clk = 1'b0;
      data_in = w[i];
      #7.5 serial_clk = 1'b1;
      r[i] = data_out;
      #7.5 if (sp && i == 8) #40;
    end
    frame_sel_n = !tie;
    data_in = !data_in;
  endtask
endmodule // asp_host

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic        sys_clk, reset, convert_start_n, serial_clk, frame_sel_n, data_in;
  logic        data_out, data_out_en, busy, ctrl_strobe;
  logic [13:0] conv_result, exp_res;
  logic [15:0] ctrl_word, w;
  int          miscompares, n_checks;
  always #4 sys_clk = !sys_clk;
  asp_host host (.*);
  asp_port #(.CONV_CYCLES(40)) uut (.*);
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok)
    begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int k;
    for (k = 0; k < 99 && s !== v; k++) @(posedge sys_clk) #1;
    chk(k < 99, "hang");
    if (k >= 99) give_verdict;
  endtask
  task automatic run(input logic [15:0] c, input bit tie, sp);
    logic [15:0] rd;
    host.xfer(c, tie, sp, 16, rd);
    chk(rd === {2'b00, exp_res}, "read");
    wait_for(ctrl_strobe, 1'b1);
    chk(ctrl_word === c, "ctrl");
  endtask
  initial
  begin
    sys_clk = 1'b0;
    reset = 1'b1;
    convert_start_n = 1'b1;
    conv_result = 14'h0000;
    exp_res = 14'h0000;
    void'($urandom(55408));
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 8; i++)
    begin
      w = {i[0] | i[1], 15'($urandom)};
      @(posedge sys_clk) conv_result <= 14'($urandom);
      run(w, i[1], i[2]);
      if (w[15])
      begin
        @(posedge sys_clk) #1 chk(busy === 1'b1, "busy");
        if (i[0]) run(16'hFFFF, i[1], 1'b0);
        wait_for(busy, 1'b0);
        exp_res = conv_result;
      end
    end
    host.xfer(16'h8000, 1'b0, 1'b0, 5, w);
    // Frame select must stand high for a while before the next frame
    repeat (4) @(posedge sys_clk);
    run(16'h1234, 1'b0, 1'b0);
    @(posedge sys_clk) conv_result <= 14'h3FFF;
    @(posedge sys_clk) convert_start_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    convert_start_n <= 1'b1;
    wait_for(busy, 1'b1);
    wait_for(busy, 1'b0);
    exp_res = 14'h3FFF;
    run(16'h0000, 1'b0, 1'b0);
    give_verdict;
  end
endmodule // tb_top
